// file: quad_dac_pkg.sv
// constants shared by the quad dac load and thermal output control logic
// assumes an 8-bit register port driven by the serial interface decoder
package quad_dac_pkg;
	// register addresses
	localparam logic [7:0] ADDR_DATA_FIRST = 8'h10;
	localparam logic [7:0] ADDR_DATA_LAST = 8'h17;
	localparam logic [7:0] ADDR_CONTROL_THREE = 8'h1a;
	localparam logic [7:0] ADDR_DAC_CONFIG = 8'h1b;
	localparam logic [7:0] ADDR_LOAD_CONFIG = 8'h1c;
	localparam logic [7:0] ADDR_INTERNAL_OFFSET = 8'h21;
	localparam logic [7:0] ADDR_EXTERNAL_OFFSET = 8'h22;

	// control_config_three fields
	localparam int FAST_CONVERSION_BIT = 0;
	localparam int THERMAL_FINE_RESOLUTION_BIT = 1;
	localparam int UPDATE_SOURCE_SELECT_BIT = 3;
	localparam int THERMAL_OUTPUT_ENABLE_A = 5;
	localparam int THERMAL_OUTPUT_ENABLE_B = 6;

	// dac_config fields
	localparam int CHANNEL_A_DOUBLE_SPAN_BIT = 0;
	localparam int SOFTWARE_LOAD_BIT_A = 4;
	localparam int SOFTWARE_LOAD_BIT_B = 5;
	localparam int PAIR_ONE_BUFFER_BIT = 6;
	localparam int PAIR_TWO_BUFFER_BIT = 7;
	localparam logic [7:0] DAC_CONFIG_STORE_MASK = 8'hcf;

	// load_config fields
	localparam int INTERNAL_REFERENCE_SELECT_BIT = 4;
	localparam int POWER_DOWN_BIT = 5;
	localparam logic [7:0] LOAD_CONFIG_STORE_MASK = 8'h30;

	// reset values
	localparam logic [7:0] CONTROL_THREE_RESET = 8'h00;
	localparam logic [7:0] DAC_CONFIG_RESET = 8'hc0;
	localparam logic [7:0] LOAD_CONFIG_RESET = 8'h00;
	localparam logic [7:0] OFFSET_RESET = 8'hd8;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// thermal code formats
	localparam int CHANNELS = 4;
	localparam int TEMPERATURE_WIDTH = 10;
	localparam int TEMPERATURE_FRACTION_BITS = 2;
	localparam int THERMAL_COARSE_BITS = 8;
	localparam int THERMAL_FINE_BITS = 10;
	localparam int MAX_RESOLUTION = 12;
endpackage : quad_dac_pkg

// file: thermal_code_mapper.sv
// maps a signed quarter-degree temperature and a whole-degree offset to a dac code
// assumes the temperature word is in the same clock domain and already stable
`timescale 1ns/1ps
module thermal_code_mapper #(
	parameter int RESOLUTION = 12
) (
	input wire logic signed [quad_dac_pkg::TEMPERATURE_WIDTH-1:0] temperature,
	input wire logic [7:0] offset,
	input wire logic fineResolution,
	output logic [RESOLUTION-1:0] code
);
	localparam int DIFF_WIDTH = quad_dac_pkg::TEMPERATURE_WIDTH + 2;
	localparam int FINE_SHIFT = quad_dac_pkg::MAX_RESOLUTION - quad_dac_pkg::THERMAL_FINE_BITS;
	localparam int COARSE_SHIFT = quad_dac_pkg::MAX_RESOLUTION - quad_dac_pkg::THERMAL_COARSE_BITS;
	localparam logic signed [DIFF_WIDTH-1:0] FINE_TOP = 12'sd1023;
	localparam logic signed [DIFF_WIDTH-1:0] COARSE_TOP = 12'sd255;

	logic signed [DIFF_WIDTH-1:0] difference;
	logic signed [DIFF_WIDTH-1:0] wholeDegrees;
	logic [quad_dac_pkg::THERMAL_FINE_BITS-1:0] fineCode;
	logic [quad_dac_pkg::THERMAL_COARSE_BITS-1:0] coarseCode;
	logic [quad_dac_pkg::MAX_RESOLUTION-1:0] aligned;
	logic useFine;

	// offset byte is two's complement whole degrees; scale to quarter degrees
	always_comb begin
		difference = DIFF_WIDTH'(temperature)
			- DIFF_WIDTH'({offset, {quad_dac_pkg::TEMPERATURE_FRACTION_BITS{1'b0}}}
			- (offset[7] ? 12'sd1024 : 12'sd0)); // [RULE_16] [RULE_18]
		wholeDegrees = difference >>> quad_dac_pkg::TEMPERATURE_FRACTION_BITS;
		useFine = fineResolution && (RESOLUTION >= quad_dac_pkg::THERMAL_FINE_BITS); // [RULE_15]
		// clamp at both ends so the output never wraps
		if (difference < 0) begin
			fineCode = '0;
		end else if (difference > FINE_TOP) begin
			fineCode = '1; // [RULE_19]
		end else begin
			fineCode = difference[quad_dac_pkg::THERMAL_FINE_BITS-1:0];
		end
		if (wholeDegrees < 0) begin
			coarseCode = '0;
		end else if (wholeDegrees > COARSE_TOP) begin
			coarseCode = '1; // [RULE_19]
		end else begin
			coarseCode = wholeDegrees[quad_dac_pkg::THERMAL_COARSE_BITS-1:0];
		end
		// left-align so one lsb of the thermal code spans 1/256 or 1/1024 of the range
		if (useFine) begin
			aligned = {fineCode, {FINE_SHIFT{1'b0}}}; // [RULE_18]
		end else begin
			aligned = {coarseCode, {COARSE_SHIFT{1'b0}}}; // [RULE_18]
		end
		code = aligned[quad_dac_pkg::MAX_RESOLUTION-1 -: RESOLUTION];
	end
endmodule : thermal_code_mapper

// file: quad_dac_control.sv
// quad dac double-buffered code registers, load control, reference and span
// selection, power-down and temperature-proportional output for channels a and b
// assumes a byte-wide register port from the serial decoder on the same clock,
// temperature results with a one-cycle valid pulse, and an asynchronous load pin
//
// Notes on behaviour
// [RULE_01] new code waits for a load command
// [RULE_02] data reads return the code driving output
// [RULE_03] load from pin edge, config bits, load register
// [RULE_04] host holds strobe low at least 20 ns
// [RULE_05] one transfer per strobe falling edge only
// [RULE_06] codes straight unsigned binary, 8/10/12 bits
// [RULE_07] pair one serves a/b, pair two c/d
// [RULE_08] each reference pair buffered or unbuffered
// [RULE_09] external reference at reset, bit selects internal
// [RULE_10] low config nibble sets per-channel double span
// [RULE_11] bit 0 spans channel a, bit 1 b
// [RULE_12] power-down turns channels off, outputs high-impedance
// [RULE_13] two control bits enable thermal output a/b
// [RULE_14] thermal code refreshes on each new measurement
// [RULE_15] thermal 8-bit default, fine bit selects 10-bit
// [RULE_16] offset register sets temperature mapping to zero
// [RULE_17] host encodes negative offset with sign bit
// [RULE_18] code is temperature minus offset, scaled
// [RULE_19] thermal code saturates at top, never wraps
// [RULE_20] pin loads at reset; bit hands over to registers
// [RULE_21] codes written as paired low/high byte registers
// [RULE_22] outputs stay zero until code written and loaded
// [RULE_23] thermal code overrides host codes on that channel
`timescale 1ns/1ps
module quad_dac_control #(
	parameter int RESOLUTION = 12
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddress,
	input wire logic [7:0] regWriteData,
	output logic [7:0] regReadData,
	output logic regReadValid,
	input wire logic outputLoadStrobe_n,
	input wire logic signed [quad_dac_pkg::TEMPERATURE_WIDTH-1:0] internalTemperature,
	input wire logic internalTemperatureValid,
	input wire logic signed [quad_dac_pkg::TEMPERATURE_WIDTH-1:0] externalTemperature,
	input wire logic externalTemperatureValid,
	output logic [quad_dac_pkg::CHANNELS-1:0][RESOLUTION-1:0] channelCode,
	output logic [quad_dac_pkg::CHANNELS-1:0] channelDrive,
	output logic [quad_dac_pkg::CHANNELS-1:0] channelDoubleSpan,
	output logic internalReferenceSelect,
	output logic referencePairOneBuffered,
	output logic referencePairTwoBuffered,
	output logic fastConversion
);
	localparam int CH = quad_dac_pkg::CHANNELS;
	localparam int WIDE = 16;

	generate
		if (!(RESOLUTION == 8 || RESOLUTION == 10 || RESOLUTION == 12)) begin : gBadResolution
			$error("quad_dac_control: RESOLUTION must be 8, 10 or 12");
		end
	endgenerate

	typedef struct packed {
		logic [CH-1:0][RESOLUTION-1:0] pending;
		logic [CH-1:0][RESOLUTION-1:0] active;
		logic [7:0] controlThree;
		logic [7:0] dacConfig;
		logic [7:0] loadConfig;
		logic [7:0] internalOffset;
		logic [7:0] externalOffset;
		logic [7:0] readData;
		logic readValid;
		logic strobeMeta;
		logic strobeSync;
		logic strobePrev;
	} state_t;

	state_t current;
	state_t next_current;

	logic [RESOLUTION-1:0] thermalCodeA;
	logic [RESOLUTION-1:0] thermalCodeB;
	logic [7:0] dataOffset;
	logic [1:0] dataChannel;
	logic dataHighByte;
	logic dataHit;
	logic [WIDE-1:0] writeWide;
	logic [WIDE-1:0] readWide;
	logic pinLoad;
	logic [CH-1:0] loadMask;
	logic [CH-1:0] thermalOwned;
	logic [CH-1:0] thermalUpdate;
	logic registerUpdates;

	thermal_code_mapper #(
		.RESOLUTION(RESOLUTION)
	) thermalMapperA (
		.temperature(internalTemperature),
		.offset(current.internalOffset),
		.fineResolution(current.controlThree[quad_dac_pkg::THERMAL_FINE_RESOLUTION_BIT]),
		.code(thermalCodeA)
	);

	thermal_code_mapper #(
		.RESOLUTION(RESOLUTION)
	) thermalMapperB (
		.temperature(externalTemperature),
		.offset(current.externalOffset),
		.fineResolution(current.controlThree[quad_dac_pkg::THERMAL_FINE_RESOLUTION_BIT]),
		.code(thermalCodeB)
	);

	// data register address split into channel and byte half
	always_comb begin
		dataOffset = regAddress - quad_dac_pkg::ADDR_DATA_FIRST;
		dataChannel = dataOffset[2:1]; // [RULE_21]
		dataHighByte = dataOffset[0];
		dataHit = (regAddress >= quad_dac_pkg::ADDR_DATA_FIRST)
			&& (regAddress <= quad_dac_pkg::ADDR_DATA_LAST); // [RULE_21]
		writeWide = WIDE'(current.pending[dataChannel]);
		// only the addressed byte of the pending copy is replaced
		if (dataHighByte) begin
			writeWide[15:8] = regWriteData;
		end else begin
			writeWide[7:0] = regWriteData;
		end
		readWide = WIDE'(current.active[dataChannel]); // [RULE_02]
	end

	// load sources and thermal ownership
	always_comb begin
		registerUpdates = current.controlThree[quad_dac_pkg::UPDATE_SOURCE_SELECT_BIT]; // [RULE_20]
		// edge seen on the synchronised pin; a held-low pin gives one load only
		pinLoad = current.strobePrev && !current.strobeSync && !registerUpdates; // [RULE_05]
		loadMask = '0;
		if (pinLoad) begin
			loadMask = '1; // [RULE_03]
		end
		if (regWrite && registerUpdates && regAddress == quad_dac_pkg::ADDR_DAC_CONFIG) begin
			if (regWriteData[quad_dac_pkg::SOFTWARE_LOAD_BIT_A]) begin
				loadMask[1:0] = 2'h3; // [RULE_03]
			end
			if (regWriteData[quad_dac_pkg::SOFTWARE_LOAD_BIT_B]) begin
				loadMask[3:2] = 2'h3; // [RULE_03]
			end
		end
		if (regWrite && registerUpdates && regAddress == quad_dac_pkg::ADDR_LOAD_CONFIG) begin
			loadMask = loadMask | regWriteData[CH-1:0]; // [RULE_03]
		end
		thermalOwned = '0;
		thermalOwned[0] = current.controlThree[quad_dac_pkg::THERMAL_OUTPUT_ENABLE_A]; // [RULE_13]
		thermalOwned[1] = current.controlThree[quad_dac_pkg::THERMAL_OUTPUT_ENABLE_B]; // [RULE_13]
		thermalUpdate = '0;
		thermalUpdate[0] = thermalOwned[0] && internalTemperatureValid; // [RULE_14]
		thermalUpdate[1] = thermalOwned[1] && externalTemperatureValid; // [RULE_14]
	end

	always_comb begin
		next_current = current;
		next_current.strobeMeta = outputLoadStrobe_n;
		next_current.strobeSync = current.strobeMeta;
		next_current.strobePrev = current.strobeSync;
		next_current.readValid = regRead;
		next_current.readData = current.readData;

		// transfer pending codes; the host path yields to thermal ownership
		for (int ch = 0; ch < CH; ch++) begin
			if (thermalOwned[ch]) begin
				if (thermalUpdate[ch]) begin
					next_current.active[ch] = (ch == 0) ? thermalCodeA : thermalCodeB; // [RULE_23]
				end
			end else if (loadMask[ch]) begin
				next_current.active[ch] = current.pending[ch]; // [RULE_01]
			end
		end

		if (regWrite) begin
			if (dataHit) begin
				// only the pending copy changes; output waits for a load
				next_current.pending[dataChannel] = writeWide[RESOLUTION-1:0]; // [RULE_01] [RULE_06]
			end else if (regAddress == quad_dac_pkg::ADDR_CONTROL_THREE) begin
				next_current.controlThree = regWriteData; // [RULE_20]
			end else if (regAddress == quad_dac_pkg::ADDR_DAC_CONFIG) begin
				// load bits act once and are not kept
				next_current.dacConfig = regWriteData & quad_dac_pkg::DAC_CONFIG_STORE_MASK; // [RULE_08] [RULE_10]
			end else if (regAddress == quad_dac_pkg::ADDR_LOAD_CONFIG) begin
				next_current.loadConfig = regWriteData & quad_dac_pkg::LOAD_CONFIG_STORE_MASK; // [RULE_09] [RULE_12]
			end else if (regAddress == quad_dac_pkg::ADDR_INTERNAL_OFFSET) begin
				next_current.internalOffset = regWriteData; // [RULE_16]
			end else if (regAddress == quad_dac_pkg::ADDR_EXTERNAL_OFFSET) begin
				next_current.externalOffset = regWriteData; // [RULE_16]
			end
		end

		if (regRead) begin
			if (dataHit) begin
				if (dataHighByte) begin
					next_current.readData = readWide[15:8]; // [RULE_02]
				end else begin
					next_current.readData = readWide[7:0]; // [RULE_02]
				end
			end else if (regAddress == quad_dac_pkg::ADDR_CONTROL_THREE) begin
				next_current.readData = current.controlThree;
			end else if (regAddress == quad_dac_pkg::ADDR_DAC_CONFIG) begin
				next_current.readData = current.dacConfig;
			end else if (regAddress == quad_dac_pkg::ADDR_LOAD_CONFIG) begin
				next_current.readData = current.loadConfig;
			end else if (regAddress == quad_dac_pkg::ADDR_INTERNAL_OFFSET) begin
				next_current.readData = current.internalOffset;
			end else if (regAddress == quad_dac_pkg::ADDR_EXTERNAL_OFFSET) begin
				next_current.readData = current.externalOffset;
			end else begin
				next_current.readData = quad_dac_pkg::READ_UNMAPPED;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			current.pending <= '0;
			current.active <= '0; // [RULE_22]
			current.controlThree <= quad_dac_pkg::CONTROL_THREE_RESET; // [RULE_20]
			current.dacConfig <= quad_dac_pkg::DAC_CONFIG_RESET;
			current.loadConfig <= quad_dac_pkg::LOAD_CONFIG_RESET; // [RULE_09]
			current.internalOffset <= quad_dac_pkg::OFFSET_RESET;
			current.externalOffset <= quad_dac_pkg::OFFSET_RESET;
			current.readData <= '0;
			current.readValid <= 1'b0;
			current.strobeMeta <= 1'b1;
			current.strobeSync <= 1'b1;
			current.strobePrev <= 1'b1;
		end else begin
			current <= next_current;
		end
	end

	always_comb begin
		channelCode = current.active; // [RULE_06]
		channelDrive = {CH{!current.loadConfig[quad_dac_pkg::POWER_DOWN_BIT]}}; // [RULE_12]
		channelDoubleSpan = current.dacConfig[quad_dac_pkg::CHANNEL_A_DOUBLE_SPAN_BIT +: CH]; // [RULE_10] [RULE_11]
		internalReferenceSelect = current.loadConfig[quad_dac_pkg::INTERNAL_REFERENCE_SELECT_BIT]; // [RULE_09]
		referencePairOneBuffered = current.dacConfig[quad_dac_pkg::PAIR_ONE_BUFFER_BIT]; // [RULE_07] [RULE_08]
		referencePairTwoBuffered = current.dacConfig[quad_dac_pkg::PAIR_TWO_BUFFER_BIT]; // [RULE_07] [RULE_08]
		fastConversion = current.controlThree[quad_dac_pkg::FAST_CONVERSION_BIT];
		regReadData = current.readData;
		regReadValid = current.readValid;
	end
endmodule : quad_dac_control

// file: quad_dac_control_asserts.sv
// checker: port relations of quad_dac_control
// assumes only the register port, the load pin and temperature pulses move the codes
`timescale 1ns/1ps
module quad_dac_control_asserts #(
	parameter int RESOLUTION = 12
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddress,
	input wire logic [7:0] regWriteData,
	input wire logic [7:0] regReadData,
	input wire logic regReadValid,
	input wire logic outputLoadStrobe_n,
	input wire logic internalTemperatureValid,
	input wire logic externalTemperatureValid,
	input wire logic [quad_dac_pkg::CHANNELS-1:0][RESOLUTION-1:0] channelCode,
	input wire logic [quad_dac_pkg::CHANNELS-1:0] channelDrive,
	input wire logic [quad_dac_pkg::CHANNELS-1:0] channelDoubleSpan,
	input wire logic internalReferenceSelect
);
	logic [7:0] ctrl3;
	logic [5:0] pinHist;
	logic pinFell, cfgWr, ldWr, anyValid;
	// a pin fall seen one to five edges back may still be loading
	assign pinFell = |(pinHist[5:1] & ~pinHist[4:0]);
	assign cfgWr = regWrite && regAddress == 8'h1b;
	assign ldWr = regWrite && regAddress == 8'h1c;
	assign anyValid = internalTemperatureValid || externalTemperatureValid;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl3 <= 8'h00;
			pinHist <= 6'h3f;
		end else begin
			pinHist <= {pinHist[4:0], outputLoadStrobe_n};
			if (regWrite && regAddress == 8'h1a) ctrl3 <= regWriteData;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	a_hold_code: assert property (
		!$stable(channelCode) |-> pinFell || $past(cfgWr || ldWr || anyValid))
		else $error("code changed without a load");
	a_span_map: assert property (
		cfgWr |=> channelDoubleSpan == $past(regWriteData[3:0]))
		else $error("span bits wrong");
	a_ref_select: assert property (
		ldWr |=> internalReferenceSelect == $past(regWriteData[4]))
		else $error("reference select wrong");
	a_power_down: assert property (
		ldWr |=> channelDrive == {4{!$past(regWriteData[5])}})
		else $error("drive enables wrong");
	a_read_active: assert property (
		regRead && regAddress == 8'h10 |=> regReadValid && regReadData == $past(channelCode[0][7:0]))
		else $error("read did not return active code");
	a_init_zero: assert property (
		$fell(rst) |-> channelCode == '0)
		else $error("code not zero after reset");
	a_thermal_owns: assert property (
		ctrl3[3] && ctrl3[5] && ldWr |=> $stable(channelCode[0]) || $past(anyValid))
		else $error("host load touched thermal channel");
	a_pin_ignored: assert property (
		ctrl3[3] && pinFell && !$past(cfgWr || ldWr || anyValid) |-> $stable(channelCode))
		else $error("pin loaded in register mode");
	c_pin_load: cover property (pinFell && !$stable(channelCode));
	c_thermal: cover property (ctrl3[5] && internalTemperatureValid);
	c_read: cover property (regRead && regAddress == 8'h10);
endmodule : quad_dac_control_asserts

bind quad_dac_control quad_dac_control_asserts #(.RESOLUTION(RESOLUTION)) quad_dac_control_asserts_i (
	.clock(clock), .rst(rst), .regWrite(regWrite), .regRead(regRead),
	.regAddress(regAddress), .regWriteData(regWriteData), .regReadData(regReadData),
	.regReadValid(regReadValid), .outputLoadStrobe_n(outputLoadStrobe_n),
	.internalTemperatureValid(internalTemperatureValid),
	.externalTemperatureValid(externalTemperatureValid), .channelCode(channelCode),
	.channelDrive(channelDrive), .channelDoubleSpan(channelDoubleSpan),
	.internalReferenceSelect(internalReferenceSelect));

// file: host_model.sv
// host model: drives the register port and the load pin
// assumes the block samples its inputs on the rising clock edge
`timescale 1ns/1ps
module host_model (
	input wire logic clock,
	input wire logic [7:0] regReadData,
	input wire logic regReadValid,
	output logic regWrite = 1'b0,
	output logic regRead = 1'b0,
	output logic [7:0] regAddress = 8'h00,
	output logic [7:0] regWriteData = 8'h00,
	output logic outputLoadStrobe_n = 1'b1
);
	// released lines show the inverse so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		{regWrite, regAddress, regWriteData} = {1'b1, a, d};
		@(posedge clock);
		#1;
		{regWrite, regAddress, regWriteData} = {1'b0, ~a, ~d};
		@(posedge clock);
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		#1;
		{regRead, regAddress} = {1'b1, a};
		@(posedge clock);
		#1;
		{regRead, regAddress} = {1'b0, ~a};
		d = regReadValid ? regReadData : 8'hxx;
	endtask : rd
	task automatic pin(input logic level);
		@(posedge clock);
		#1;
		outputLoadStrobe_n = level;
	endtask : pin
	task automatic pulse;
		repeat (3) pin(1'b0);
		pin(1'b1);
		repeat (6) @(posedge clock);
		#1;
	endtask : pulse
endmodule : host_model

// file: tb_top.sv
// self-checking bench for quad_dac_control with host_model on the register port
// assumes RES is 12, so expected codes are 12-bit values
`timescale 1ns/1ps
module tb_top;
	localparam int RES = 12;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic regWrite, regRead, regReadValid, outputLoadStrobe_n;
	logic [7:0] regAddress, regWriteData, regReadData, rdata;
	logic signed [quad_dac_pkg::TEMPERATURE_WIDTH-1:0] intTemp = '0, extTemp = '0;
	logic intValid = 1'b0, extValid = 1'b0;
	logic [quad_dac_pkg::CHANNELS-1:0][RES-1:0] channelCode;
	logic [3:0] channelDrive, channelDoubleSpan;
	logic refSel, pairOne, pairTwo, fastConv;
	int n_fail = 0;
	int checks_done = 0;
	initial forever #5 clock = ~clock;
	quad_dac_control #(.RESOLUTION(RES)) quad_dac_control_i (.clock(clock), .rst(rst),
		.regWrite(regWrite), .regRead(regRead), .regAddress(regAddress),
		.regWriteData(regWriteData), .regReadData(regReadData), .regReadValid(regReadValid),
		.outputLoadStrobe_n(outputLoadStrobe_n), .internalTemperature(intTemp),
		.internalTemperatureValid(intValid), .externalTemperature(extTemp),
		.externalTemperatureValid(extValid), .channelCode(channelCode),
		.channelDrive(channelDrive), .channelDoubleSpan(channelDoubleSpan),
		.internalReferenceSelect(refSel), .referencePairOneBuffered(pairOne),
		.referencePairTwoBuffered(pairTwo), .fastConversion(fastConv));
	host_model host_model_i (.clock(clock), .regReadData(regReadData),
		.regReadValid(regReadValid), .regWrite(regWrite), .regRead(regRead),
		.regAddress(regAddress), .regWriteData(regWriteData),
		.outputLoadStrobe_n(outputLoadStrobe_n));
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
		checks_done++;
		if (got !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, e, got);
		end
	endtask : chk
	task automatic cchk(input int ch, input logic [RES-1:0] e);
		chk($sformatf("code %0d", ch), 16'(e), 16'(channelCode[ch]));
	endtask : cchk
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		host_model_i.rd(a, rdata);
		chk($sformatf("read %h", a), 16'(e), 16'(rdata));
	endtask : rdchk
	task automatic waitn(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : waitn
	task automatic temp(input logic ext, input logic signed [9:0] t);
		@(posedge clock);
		#1;
		{intTemp, extTemp, intValid, extValid} = {t, t, !ext, ext};
		waitn(1);
		{intValid, extValid} = 2'b00;
		waitn(1);
	endtask : temp
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : print_verdict
	initial begin
		waitn(5);
		rst = 1'b0;
		cchk(0, 12'h000);
		chk("drive", 16'h000f, 16'(channelDrive));
		chk("buffered", 16'h0003, 16'({pairTwo, pairOne}));
		chk("refsel", 16'h0000, 16'(refSel));
		chk("fast", 16'h0000, 16'(fastConv));
		rdchk(8'h1b, 8'hc0);
		rdchk(8'h1c, 8'h00);
		rdchk(8'h21, 8'hd8);
		host_model_i.wr(8'h10, 8'h55);
		host_model_i.wr(8'h11, 8'h0a);
		host_model_i.wr(8'h14, 8'h77);
		cchk(0, 12'h000);
		rdchk(8'h10, 8'h00);
		host_model_i.pin(1'b0);
		waitn(6);
		cchk(0, 12'ha55);
		cchk(2, 12'h077);
		host_model_i.wr(8'h14, 8'h12);
		waitn(6);
		cchk(2, 12'h077);
		host_model_i.pin(1'b1);
		waitn(6);
		cchk(2, 12'h077);
		host_model_i.pulse();
		cchk(2, 12'h012);
		rdchk(8'h11, 8'h0a);
		host_model_i.wr(8'h1a, 8'h08);
		host_model_i.wr(8'h12, 8'h34);
		host_model_i.wr(8'h16, 8'h99);
		host_model_i.pulse();
		cchk(3, 12'h000);
		host_model_i.wr(8'h1b, 8'hd0);
		cchk(1, 12'h034);
		cchk(3, 12'h000);
		host_model_i.wr(8'h1c, 8'h08);
		cchk(3, 12'h099);
		host_model_i.wr(8'h1b, 8'h02);
		chk("span", 16'h0002, 16'(channelDoubleSpan));
		chk("buffered", 16'h0000, 16'({pairTwo, pairOne}));
		host_model_i.wr(8'h1c, 8'h30);
		chk("refsel", 16'h0001, 16'(refSel));
		chk("drive", 16'h0000, 16'(channelDrive));
		host_model_i.wr(8'h1c, 8'h00);
		chk("drive", 16'h000f, 16'(channelDrive));
		host_model_i.wr(8'h1a, 8'h68);
		temp(1'b0, 10'sd0);
		cchk(0, 12'h280);
		temp(1'b1, 10'sd508);
		cchk(1, 12'ha70);
		host_model_i.wr(8'h10, 8'hee);
		host_model_i.wr(8'h1c, 8'h03);
		cchk(0, 12'h280);
		host_model_i.wr(8'h1a, 8'h6b);
		chk("fast", 16'h0001, 16'(fastConv));
		host_model_i.wr(8'h21, 8'h80);
		temp(1'b0, 10'sd511);
		cchk(0, 12'hffc);
		host_model_i.wr(8'h22, 8'h0a);
		temp(1'b1, -10'sd80);
		cchk(1, 12'h000);
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		print_verdict();
	end
endmodule : tb_top
